// ---- include/ctrw_pkg.sv ----
// Constants, types and helpers shared by the core timer block.
// Assumes a single bus clock; all counts are in bus clock cycles.
package ctrw_pkg;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [15:0] IDX_CTRL_STATUS = 16'h0008;
  localparam logic [15:0] IDX_COUNT = 16'h0009;
  localparam logic [15:0] IDX_EVT_STATUS = 16'h000A;
  localparam logic [15:0] IDX_EVT_MASK = 16'h000B;
  localparam logic [15:0] IDX_SERVICE = 16'h3FF0;

  function automatic logic [31:0] ctrw_byte_addr(input logic [15:0] idx);
    return {14'h0000, idx, 2'b00};
  endfunction

  // Control/status field positions
  localparam int unsigned CS_WRAP_FLAG = 7;
  localparam int unsigned CS_TICK_FLAG = 6;
  localparam int unsigned CS_WRAP_EN = 5;
  localparam int unsigned CS_TICK_EN = 4;
  localparam int unsigned CS_WRAP_CLR = 3;
  localparam int unsigned CS_TICK_CLR = 2;
  localparam int unsigned CS_RATE_HI = 1;
  localparam int unsigned CS_RATE_LO = 0;
  localparam logic [1:0] CS_RATE_RST = 2'h3;
  localparam int unsigned SERVICE_BIT = 0;

  // Divider chain shape
  localparam int unsigned PRESCALE_BITS = 2;
  localparam int unsigned COUNT_BITS = 8;
  localparam int unsigned PRE_TICK_BITS = 4;
  localparam int unsigned TICK_STAGES = 3;
  localparam int unsigned WDOG_STAGES = 3;
  localparam logic [31:0] POR_RELEASE_CYCLES = 32'h00000FE0;

  // Events seen by the interrupt status and mask registers
  typedef struct packed {
    logic wdog;
    logic tick;
    logic wrap;
  } ctrw_evt_t;

  typedef enum logic [1:0] {MODE_RESTART, MODE_RUN, MODE_STOPPED} ctrw_mode_t;

  // True when the low n bits of v are all ones
  function automatic logic ctrw_low_ones(input logic [31:0] v, input int unsigned n);
    logic [31:0] m;
    m = (32'h00000001 << n) - 32'h00000001;
    return (v & m) == m;
  endfunction

endpackage

// ---- hdl/ctrw_rst_sync.sv ----
// Reset release synchroniser for the core timer.
// Assumes RESETN may fall at any time; release is aligned to clk.
`timescale 1ns/1ps
module ctrw_rst_sync (
  // Clock and raw reset
  input wire logic clk,
  input wire logic rst_in_n,
  // Synchronised reset
  output logic rst_out_n
);
  logic meta_q;

  always_ff @(posedge clk or negedge rst_in_n) begin
    if (!rst_in_n) begin
      meta_q <= 1'b0;
      rst_out_n <= 1'b0;
    end else begin
      meta_q <= 1'b1;
      rst_out_n <= meta_q;
    end
  end
endmodule

// ---- hdl/ctrw_chain.sv ----
// Divider chain: prescaler, readable counter, periodic taps, watchdog.
// Assumes clear and run come from the controller on the same clock.
`timescale 1ns/1ps
module ctrw_chain #(
  parameter int unsigned PRE_BITS = ctrw_pkg::PRESCALE_BITS,
  parameter int unsigned CNT_BITS = ctrw_pkg::COUNT_BITS,
  parameter int unsigned PRE_TICK = ctrw_pkg::PRE_TICK_BITS,
  parameter int unsigned TICK_STG = ctrw_pkg::TICK_STAGES,
  parameter int unsigned WDOG_STG = ctrw_pkg::WDOG_STAGES,
  parameter bit WDOG_PRESENT = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic clear,
  input wire logic run,
  input wire logic [1:0] rate_sel,
  input wire logic wdog_service,
  // Results
  output logic [CNT_BITS-1:0] count,
  output logic wrap,
  output logic tick,
  output logic wdog_expire,
  output logic por_done
);
  localparam int unsigned CHAIN_W = PRE_BITS + CNT_BITS + PRE_TICK + TICK_STG;
  localparam int unsigned TAP0 = PRE_BITS + CNT_BITS + PRE_TICK;

  logic [CHAIN_W-1:0] chain_q;
  logic [31:0] chain_x;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) chain_q <= '0;
    else if (clear) chain_q <= '0;
    else if (run) chain_q <= chain_q + 1'b1;
  end

  assign chain_x = 32'(chain_q);
  assign count = chain_q[PRE_BITS +: CNT_BITS];
  assign wrap = run && ctrw_pkg::ctrw_low_ones(chain_x, PRE_BITS + CNT_BITS); // [R2] [R18]
  // Tap n fires once per 2^(14+n) bus cycles
  assign tick = run && ctrw_pkg::ctrw_low_ones(chain_x, TAP0 + 32'(rate_sel)); // [R1] [R7]
  assign por_done = run && (chain_x == ctrw_pkg::POR_RELEASE_CYCLES - 32'h1); // [R18]

  if (WDOG_PRESENT) begin : g_wdog // [R14]
    logic [WDOG_STG-1:0] wdog_q;
    // Service clears only this stage; the rest of the chain runs on
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) wdog_q <= '0;
      else if (clear || wdog_service) wdog_q <= '0; // [R13]
      else if (tick) wdog_q <= wdog_q + 1'b1; // [R11]
    end
    assign wdog_expire = tick && (&wdog_q); // [R11]
  end else begin : g_no_wdog
    assign wdog_expire = 1'b0;
  end
endmodule

// ---- hdl/ctrw_core_timer.sv ----
// Core timer top: AHB-Lite register slave, flags, interrupts, low-power
// modes and the watchdog reset request.
// Assumes a single bus clock CLK; CPU_IRQ_MASK, WAIT_MODE, STOP_ENTER and
// STOP_EXIT are synchronous to it; only whole-word single transfers.
`timescale 1ns/1ps

// Operation
// R1: Periodic section divides bus clock by 16384, then three stages, one of four taps.
// R2: Counter wrap from FF to 00 sets wrap flag; interrupt if enabled.
// R3: Writing one to wrap clear bit clears wrap flag; flag not writable.
// R4: Selected tap firing sets the periodic flag; interrupt if enabled.
// R5: Writing one to periodic clear bit clears periodic flag; reset clears it.
// R6: Processor request when enabled flag set and global mask clear.
// R7: Rate select 00..11 gives division 2^14, 2^15, 2^16, 2^17.
// R8: Reset sets rate select to 11; same field sets watchdog period.
// R9: Software services watchdog before changing rate, else a tick may slip.
// R10: Count register is read-only 8-bit counter value, reset to zero.
// R11: Watchdog divides selected tap by eight; timeout is 7 to 8 periods.
// R12: Watchdog expiry raises an internal reset.
// R13: Writing zero to service bit 0 clears only the watchdog stage.
// R14: Watchdog presence is a build-time parameter.
// R15: Chain runs in wait; an enabled timer interrupt wakes the processor.
// R16: Stop clears chain; on exit wait restart delay, clear, then resume.
// R17: Control/status bits 7..0: flags, enables, clear bits, rate select.
// R18: Counter runs at bus clock over four; wrap and release delay from chain.
// R19: Clear bits read zero, store nothing; writing zero has no effect.
module ctrw_core_timer #(
  parameter int unsigned PRE_TICK = ctrw_pkg::PRE_TICK_BITS,
  parameter int unsigned TICK_STG = ctrw_pkg::TICK_STAGES,
  parameter bit WDOG_PRESENT = 1'b1
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  // Processor side
  input wire logic CPU_IRQ_MASK,
  input wire logic WAIT_MODE,
  input wire logic STOP_ENTER,
  input wire logic STOP_EXIT,
  output logic CPU_IRQ,
  output logic CPU_WAKE,
  output logic WDOG_RESET,
  output logic CHAIN_RUNNING,
  // Event interrupt
  output logic IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset

  logic rst_n;

  ctrw_rst_sync u_rst_sync (
    .clk(CLK),
    .rst_in_n(RESETN),
    .rst_out_n(rst_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  ctrw_pkg::ctrw_mode_t mode_q;
  ctrw_pkg::ctrw_mode_t mode_d;
  ctrw_pkg::ctrw_evt_t evt_status_q;
  ctrw_pkg::ctrw_evt_t evt_mask_q;
  ctrw_pkg::ctrw_evt_t evt_now;
  ctrw_pkg::ctrw_evt_t evt_clr;
  logic chain_clear;
  logic chain_run;
  logic [ctrw_pkg::COUNT_BITS-1:0] count;
  logic wrap;
  logic tick;
  logic wdog_expire;
  logic por_done;
  logic wdog_rst_q;
  logic wrap_flag_q;
  logic tick_flag_q;
  logic wrap_en_q;
  logic tick_en_q;
  logic [1:0] rate_q;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [31:0] addr_q;
  logic accept;
  logic [7:0] rd_mux;
  logic wr_cs;
  logic wr_service;
  logic wr_evt_status;
  logic wr_evt_mask;
  logic irq_req;

  ////////////////////////////////////////////////////////////////////////////
  // Divider chain

  ctrw_chain #(
    .PRE_BITS(ctrw_pkg::PRESCALE_BITS),
    .CNT_BITS(ctrw_pkg::COUNT_BITS),
    .PRE_TICK(PRE_TICK),
    .TICK_STG(TICK_STG),
    .WDOG_STG(ctrw_pkg::WDOG_STAGES),
    .WDOG_PRESENT(WDOG_PRESENT)
  ) u_chain (
    .clk(CLK),
    .rst_n(rst_n),
    .clear(chain_clear),
    .run(chain_run),
    .rate_sel(rate_q),
    .wdog_service(wr_service),
    .count(count),
    .wrap(wrap),
    .tick(tick),
    .wdog_expire(wdog_expire),
    .por_done(por_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mode control: power-on and stop restart share one release delay

  always_comb begin
    mode_d = mode_q;
    chain_clear = 1'b0;
    unique case (mode_q)
      ctrw_pkg::MODE_RESTART: begin
        if (por_done) begin
          mode_d = ctrw_pkg::MODE_RUN;
          chain_clear = 1'b1; // [R16] [R18]
        end
      end
      ctrw_pkg::MODE_RUN: begin
        if (STOP_ENTER) begin
          mode_d = ctrw_pkg::MODE_STOPPED;
          chain_clear = 1'b1; // [R16]
        end
      end
      ctrw_pkg::MODE_STOPPED: begin
        if (STOP_EXIT) mode_d = ctrw_pkg::MODE_RESTART; // [R16]
      end
    endcase
    // Internal reset clears the chain and resumes without a restart delay
    if (wdog_rst_q) begin
      mode_d = ctrw_pkg::MODE_RUN;
      chain_clear = 1'b1; // [R12]
    end
  end

  // Chain keeps running in wait; only stop halts it
  assign chain_run = (mode_q != ctrw_pkg::MODE_STOPPED); // [R15]

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) mode_q <= ctrw_pkg::MODE_RESTART;
    else mode_q <= mode_d;
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) CHAIN_RUNNING <= 1'b0;
    else CHAIN_RUNNING <= (mode_d == ctrw_pkg::MODE_RUN);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog reset request

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) wdog_rst_q <= 1'b0;
    else wdog_rst_q <= wdog_expire && (mode_q == ctrw_pkg::MODE_RUN); // [R12]
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) WDOG_RESET <= 1'b0;
    else WDOG_RESET <= wdog_expire && (mode_q == ctrw_pkg::MODE_RUN); // [R12] [R14]
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: writes zero wait, reads one wait state

  assign accept = HSEL && HTRANS[1] && HREADY;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 32'h00000000;
    end else begin
      wr_pend_q <= accept && HWRITE;
      rd_pend_q <= accept && !HWRITE;
      if (accept) addr_q <= HADDR;
    end
  end

  // Read data sampled a cycle late so a write just before is visible
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      HREADYOUT <= 1'b1;
      HRDATA <= 32'h00000000;
    end else begin
      HREADYOUT <= !(accept && !HWRITE);
      if (rd_pend_q) HRDATA <= {24'h000000, rd_mux};
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) HRESP <= 1'b0;
    else HRESP <= 1'b0;
  end

  assign wr_cs = wr_pend_q && (addr_q == ctrw_pkg::ctrw_byte_addr(ctrw_pkg::IDX_CTRL_STATUS));
  assign wr_evt_status = wr_pend_q
    && (addr_q == ctrw_pkg::ctrw_byte_addr(ctrw_pkg::IDX_EVT_STATUS));
  assign wr_evt_mask = wr_pend_q
    && (addr_q == ctrw_pkg::ctrw_byte_addr(ctrw_pkg::IDX_EVT_MASK));
  assign wr_service = wr_pend_q && !HWDATA[ctrw_pkg::SERVICE_BIT]
    && (addr_q == ctrw_pkg::ctrw_byte_addr(ctrw_pkg::IDX_SERVICE)); // [R13]

  always_comb begin
    rd_mux = 8'h00;
    if (addr_q == ctrw_pkg::ctrw_byte_addr(ctrw_pkg::IDX_CTRL_STATUS)) begin
      rd_mux[ctrw_pkg::CS_WRAP_FLAG] = wrap_flag_q; // [R17]
      rd_mux[ctrw_pkg::CS_TICK_FLAG] = tick_flag_q;
      rd_mux[ctrw_pkg::CS_WRAP_EN] = wrap_en_q;
      rd_mux[ctrw_pkg::CS_TICK_EN] = tick_en_q;
      rd_mux[ctrw_pkg::CS_RATE_HI] = rate_q[1];
      rd_mux[ctrw_pkg::CS_RATE_LO] = rate_q[0]; // clear bits stay zero [R19]
    end else if (addr_q == ctrw_pkg::ctrw_byte_addr(ctrw_pkg::IDX_COUNT)) begin
      rd_mux = count; // [R10]
    end else if (addr_q == ctrw_pkg::ctrw_byte_addr(ctrw_pkg::IDX_EVT_STATUS)) begin
      rd_mux = {5'h00, evt_status_q};
    end else if (addr_q == ctrw_pkg::ctrw_byte_addr(ctrw_pkg::IDX_EVT_MASK)) begin
      rd_mux = {5'h00, evt_mask_q};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control/status register

  // Count register has no write path, so writes to it are dropped [R10]
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      wrap_en_q <= 1'b0;
      tick_en_q <= 1'b0;
      rate_q <= ctrw_pkg::CS_RATE_RST; // [R8]
    end else if (wdog_rst_q) begin
      wrap_en_q <= 1'b0;
      tick_en_q <= 1'b0;
      rate_q <= ctrw_pkg::CS_RATE_RST; // [R8]
    end else if (wr_cs) begin
      wrap_en_q <= HWDATA[ctrw_pkg::CS_WRAP_EN];
      tick_en_q <= HWDATA[ctrw_pkg::CS_TICK_EN];
      // Changing rate near a tap edge may slip one tick [R9]
      rate_q <= {HWDATA[ctrw_pkg::CS_RATE_HI], HWDATA[ctrw_pkg::CS_RATE_LO]}; // [R7]
    end
  end

  // Flags: a new event in the clear cycle wins over the clear
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) wrap_flag_q <= 1'b0;
    else if (wdog_rst_q) wrap_flag_q <= 1'b0;
    else if (evt_now.wrap) wrap_flag_q <= 1'b1; // [R2]
    else if (wr_cs && HWDATA[ctrw_pkg::CS_WRAP_CLR]) wrap_flag_q <= 1'b0; // [R3] [R19]
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) tick_flag_q <= 1'b0; // [R5]
    else if (wdog_rst_q) tick_flag_q <= 1'b0; // [R5]
    else if (evt_now.tick) tick_flag_q <= 1'b1; // [R4]
    else if (wr_cs && HWDATA[ctrw_pkg::CS_TICK_CLR]) tick_flag_q <= 1'b0; // [R5] [R19]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Processor request and wake

  // Events only count once the release delay has passed
  assign evt_now.wrap = wrap && (mode_q == ctrw_pkg::MODE_RUN);
  assign evt_now.tick = tick && (mode_q == ctrw_pkg::MODE_RUN);
  assign evt_now.wdog = wdog_expire && (mode_q == ctrw_pkg::MODE_RUN);

  assign irq_req = (wrap_flag_q && wrap_en_q) || (tick_flag_q && tick_en_q); // [R2] [R4]

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) CPU_IRQ <= 1'b0;
    else CPU_IRQ <= irq_req && !CPU_IRQ_MASK; // [R6]
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) CPU_WAKE <= 1'b0;
    else CPU_WAKE <= irq_req && WAIT_MODE; // [R15]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event status and mask; status survives the watchdog reset

  assign evt_clr = wr_evt_status ? ctrw_pkg::ctrw_evt_t'(HWDATA[2:0]) : '0;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) evt_status_q <= '0;
    else evt_status_q <= evt_now | (evt_status_q & ~evt_clr);
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) evt_mask_q <= '0;
    else if (wr_evt_mask) evt_mask_q <= ctrw_pkg::ctrw_evt_t'(HWDATA[2:0]);
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) IRQ <= 1'b0;
    else IRQ <= |(evt_status_q & evt_mask_q);
  end

endmodule

// ---- sim/ctrw_core_timer_chk.sv ----
// Port checker for the core timer: bus wait states, interrupt gating, stop and restart.
// Assumes it is bound to ctrw_core_timer and sees only its ports.
`timescale 1ns/1ps
module ctrw_core_timer_chk (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Bus
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  // Processor side
  input wire logic CPU_IRQ_MASK,
  input wire logic WAIT_MODE,
  input wire logic STOP_ENTER,
  input wire logic CPU_IRQ,
  input wire logic CPU_WAKE,
  input wire logic WDOG_RESET,
  input wire logic CHAIN_RUNNING
);
  localparam int RESTART_MIN = 4064;
  logic [12:0] idle_q;
  logic take;
  assign take = HSEL && HTRANS[1] && HREADY;
  // Saturates so a long stop cannot wrap
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      idle_q <= 13'h0000;
    end else if (CHAIN_RUNNING) begin
      idle_q <= 13'h0000;
    end else if (idle_q != 13'h1FFF) begin
      idle_q <= idle_q + 13'h0001;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  ////////////////////////////////////////////////////////////////////////////
  property p_rd_wait;
    take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  property p_okay;
    !HRESP;
  endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_irq_mask;
    CPU_IRQ |-> !$past(CPU_IRQ_MASK);
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("request while masked");
  property p_wake;
    CPU_WAKE |-> $past(WAIT_MODE);
  endproperty
  a_wake: assert property (p_wake) else $error("wake outside wait");
  property p_wd_pulse;
    WDOG_RESET |=> !WDOG_RESET;
  endproperty
  a_wd_pulse: assert property (p_wd_pulse) else $error("reset pulse too long");
  property p_wd_run;
    WDOG_RESET |-> $past(CHAIN_RUNNING);
  endproperty
  a_wd_run: assert property (p_wd_run) else $error("expiry while halted");
  property p_stop;
    CHAIN_RUNNING && STOP_ENTER |=> !CHAIN_RUNNING;
  endproperty
  a_stop: assert property (p_stop) else $error("stop ignored");
  property p_restart;
    $rose(CHAIN_RUNNING) |-> idle_q >= RESTART_MIN;
  endproperty
  a_restart: assert property (p_restart) else $error("restart too early");
endmodule

bind ctrw_core_timer ctrw_core_timer_chk i_chk (
  .CLK(CLK), .RESETN(RESETN), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CPU_IRQ_MASK(CPU_IRQ_MASK),
  .WAIT_MODE(WAIT_MODE), .STOP_ENTER(STOP_ENTER), .CPU_IRQ(CPU_IRQ), .CPU_WAKE(CPU_WAKE),
  .WDOG_RESET(WDOG_RESET), .CHAIN_RUNNING(CHAIN_RUNNING)
);

// ---- sim/tb.sv ----
// Self-checking bench for the core timer over AHB-Lite.
// Assumes one slave, so HREADY is fed back from HREADYOUT.
`timescale 1ns/1ps
module tb;
  logic CLK, RESETN, HSEL, HWRITE, HREADY, HREADYOUT, HRESP, IRQ;
  logic CPU_IRQ_MASK, WAIT_MODE, STOP_ENTER, STOP_EXIT, CPU_IRQ, CPU_WAKE, WDOG_RESET;
  logic CHAIN_RUNNING;
  logic [31:0] HADDR, HWDATA, HRDATA, rd, rnd;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE;
  int fails = 0, num_checks = 0, cyc = 0, t0, r;
  // Rate table model: expected tick period for each rate code, in order
  int exp_q[$];
  // Shortened chain: tick period is 2^(10+PRE+rate)
  localparam int unsigned PRE = 1;
  localparam int P = 1 << (10 + PRE);
  localparam logic [15:0] A_CS = ctrw_pkg::IDX_CTRL_STATUS;
  localparam logic [15:0] A_ST = ctrw_pkg::IDX_EVT_STATUS;
  localparam logic [15:0] A_MK = ctrw_pkg::IDX_EVT_MASK;
  localparam logic [15:0] A_SV = ctrw_pkg::IDX_SERVICE;
  assign HREADY = HREADYOUT;
  // All three tap stages kept, else rate code 11 has no tap
  ctrw_core_timer #(.PRE_TICK(PRE), .TICK_STG(3), .WDOG_PRESENT(1'b1)) i_ctrw_core_timer (
    .CLK(CLK), .RESETN(RESETN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA), .CPU_IRQ_MASK(CPU_IRQ_MASK),
    .WAIT_MODE(WAIT_MODE), .STOP_ENTER(STOP_ENTER), .STOP_EXIT(STOP_EXIT),
    .CPU_IRQ(CPU_IRQ), .CPU_WAKE(CPU_WAKE), .WDOG_RESET(WDOG_RESET),
    .CHAIN_RUNNING(CHAIN_RUNNING), .IRQ(IRQ));
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  always @(posedge CLK) cyc <= cyc + 1;
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    num_checks++;
    if (got < lo || got > hi) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  function automatic logic cond(input int k);
    case (k)
      0: return HREADYOUT === 1'b1;
      1: return IRQ === 1'b1;
      2: return IRQ === 1'b0;
      3: return WDOG_RESET === 1'b1;
      4: return CHAIN_RUNNING === 1'b1;
      default: return CPU_IRQ === 1'b1;
    endcase
  endfunction
  // Every wait is bounded; running out ends the run
  task automatic wait_for(input int k, input int lim);
    int n;
    n = 0;
    while (!cond(k)) begin
      @(posedge CLK);
      n++;
      if (n > lim) begin
        fails++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, n, lim);
        tally_and_finish();
      end
    end
  endtask
  task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {14'h0000, idx, 2'b00};
    @(posedge CLK);
    wait_for(0, 20);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    @(posedge CLK);
    wait_for(0, 20);
    rd = HRDATA;
  endtask
  task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp, input logic [31:0] m);
    bus(1'b0, idx, 32'h00000000);
    chk(rd & m, exp);
  endtask
  task automatic pulse(input int k);
    if (k == 0) STOP_ENTER <= 1'b1;
    else STOP_EXIT <= 1'b1;
    @(posedge CLK);
    STOP_ENTER <= 1'b0;
    STOP_EXIT <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {RESETN, HSEL, HWRITE, CPU_IRQ_MASK, WAIT_MODE, STOP_ENTER, STOP_EXIT} = 7'h00;
    {HADDR, HWDATA, HTRANS} = 66'h0;
    HSIZE = 3'h2;
    rnd = $urandom(56);
    repeat (8) @(posedge CLK);
    RESETN <= 1'b1;
    t0 = cyc;
    wait_for(4, 5000);
    chk_rng(cyc - t0, 4064, 4072);
    rdchk(A_CS, 32'h03, 32'hFFFFFFFF);
    rdchk(A_MK, 32'h0, 32'hFFFFFFFF);
    rdchk(16'h0020, 32'h0, 32'hFFFFFFFF);
    rnd = $urandom;
    bus(1'b1, A_MK, rnd);
    rdchk(A_MK, rnd & 32'h7, 32'hFFFFFFFF);
    bus(1'b1, A_CS, 32'hCC);
    rdchk(A_CS, 32'h00, 32'hFFFFFFBF);
    $display("test registers done");
    bus(1'b1, A_CS, 32'h23);
    wait_for(5, 1200);
    rdchk(A_CS, 32'hA3, 32'hFFFFFFBF);
    CPU_IRQ_MASK <= 1'b1;
    WAIT_MODE <= 1'b1;
    repeat (2) @(posedge CLK);
    chk(CPU_IRQ, 0);
    chk(CPU_WAKE, 1);
    CPU_IRQ_MASK <= 1'b0;
    WAIT_MODE <= 1'b0;
    bus(1'b1, A_CS, 32'h23);
    rdchk(A_CS, 32'hA3, 32'hFFFFFFBF);
    bus(1'b1, A_CS, 32'h2B);
    rdchk(A_CS, 32'h23, 32'hFFFFFFBF);
    repeat (2) @(posedge CLK);
    chk(CPU_IRQ, 0);
    $display("test wrap flag done");
    for (r = 0; r < 4; r++) exp_q.push_back(P << r);
    for (r = 0; r < 4; r++) begin
      bus(1'b1, A_SV, 32'h0);
      bus(1'b1, A_CS, r);
      bus(1'b1, A_MK, 32'h2);
      bus(1'b1, A_ST, 32'h7);
      // Stale tick status from the last pass keeps IRQ up for two edges
      wait_for(2, 10);
      wait_for(1, 20000);
      t0 = cyc;
      bus(1'b1, A_ST, 32'h2);
      wait_for(2, 10);
      wait_for(1, 20000);
      chk(cyc - t0, exp_q.pop_front());
      rdchk(A_CS, 32'h40 | r, 32'h7F);
      bus(1'b1, A_CS, 32'h04 | r);
      rdchk(A_CS, r, 32'h7F);
    end
    $display("test tick rates done");
    bus(1'b1, A_CS, 32'h0);
    bus(1'b1, A_MK, 32'h4);
    bus(1'b1, A_SV, 32'h0);
    t0 = cyc;
    repeat (4 * P) @(posedge CLK);
    bus(1'b1, A_SV, 32'h1);
    wait_for(3, 20000);
    chk_rng(cyc - t0, 7 * P, 8 * P + 4);
    wait_for(1, 4);
    rdchk(A_CS, 32'h03, 32'hFFFFFFFF);
    rdchk(A_ST, 32'h4, 32'h4);
    bus(1'b1, A_ST, 32'h7);
    wait_for(2, 4);
    $display("test watchdog done");
    pulse(0);
    @(posedge CLK);
    chk(CHAIN_RUNNING, 0);
    rdchk(ctrw_pkg::IDX_COUNT, 32'h0, 32'hFFFFFFFF);
    bus(1'b1, ctrw_pkg::IDX_COUNT, 32'hFF);
    rdchk(ctrw_pkg::IDX_COUNT, 32'h0, 32'hFFFFFFFF);
    pulse(1);
    t0 = cyc;
    wait_for(4, 5000);
    chk_rng(cyc - t0, 4064, 4068);
    repeat (400) @(posedge CLK);
    bus(1'b0, ctrw_pkg::IDX_COUNT, 32'h0);
    chk_rng(rd, 99, 104);
    $display("test stop done");
    tally_and_finish();
  end
endmodule
